// [design/acs_ctrl.sv]
// module: converter control register with start source selection
`timescale 1ns/1ps
module acs_ctrl
  import acs_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // special-function bus
  input wire acs_pkg::acs_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  // converter core
  input wire acs_pkg::acs_core_evt_t core_evt,
  input wire acs_pkg::acs_limits_t limits,
  output logic converter_on,
  output logic burst_sequence_on,
  output logic conv_start,
  // start triggers
  input wire acs_pkg::acs_trig_t trig,
  // flag levels toward the interrupt controller
  output logic done_flag_out,
  output logic window_flag_out
);

  typedef struct packed {
    acs_ctrl_t ctrl;
    logic pin_prev;
    logic start;
    logic [7:0] rdata;
  } acs_state_t;

  acs_state_t state_reg;
  acs_state_t state_next;
  logic win_match;
  logic ctrl_wr;
  logic sw_go;
  logic hw_go;
  logic done_evt;
  acs_ctrl_t wr_ctrl;

  ////////////////////////////////////////////////////////////////////////////
  // window comparison of the incoming result
  acs_window u_window (
    .result(core_evt.conversion_result),
    .limits(limits),
    .match(win_match)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decode of bus write and trigger sources
  assign ctrl_wr = sfr_req.wr && (sfr_req.addr == ACS_CTRL_ADDR);
  assign wr_ctrl = acs_ctrl_t'(sfr_req.wdata);
  assign sw_go = ctrl_wr && wr_ctrl.conversion_trigger_busy &&
                 (wr_ctrl.start_source_select == ACS_SRC_SW); // R4
  // done follows the mode in force when the core reports
  assign done_evt = state_reg.ctrl.burst_sequence_on ?
                    core_evt.burst_end : core_evt.conv_end; // R3

  // hardware sources use the code held before any write this cycle
  always_comb
  begin
    unique case (state_reg.ctrl.start_source_select)
      ACS_SRC_SW: hw_go = 1'b0;
      ACS_SRC_TMR0: hw_go = trig.tmr0_ovf; // R6
      ACS_SRC_TMR2: hw_go = trig.tmr2_ovf; // R7
      ACS_SRC_TMR3: hw_go = trig.tmr3_ovf; // R8
      ACS_SRC_PIN: hw_go = trig.external_start_pin &&
                           !state_reg.pin_prev; // R9
      default: hw_go = 1'b0; // reserved codes start nothing
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state: software write first, then hardware sets so sets win
  always_comb
  begin
    state_next = state_reg;
    state_next.start = 1'b0;
    state_next.pin_prev = trig.external_start_pin;
    if (sfr_req.rd)
    begin
      state_next.rdata = (sfr_req.addr == ACS_CTRL_ADDR) ?
                         state_reg.ctrl : 8'h00_00;
    end
    if (ctrl_wr)
    begin
      state_next.ctrl = wr_ctrl;
      // busy is owned by hardware; writing 0 has no effect
      state_next.ctrl.conversion_trigger_busy =
        state_reg.ctrl.conversion_trigger_busy;
    end
    if (done_evt)
    begin
      state_next.ctrl.conversion_done_flag = 1'b1; // R3
      state_next.ctrl.conversion_trigger_busy = 1'b0;
    end
    // a start is refused while off or while a conversion is running
    if ((sw_go || hw_go) && state_next.ctrl.converter_on &&
        !state_reg.ctrl.conversion_trigger_busy) // R15
    begin
      state_next.start = 1'b1;
      state_next.ctrl.conversion_trigger_busy = 1'b1;
    end
    if (core_evt.result_valid && win_match)
    begin
      state_next.ctrl.window_match_flag = 1'b1; // R11
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      state_reg <= '0; // R13
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from the state register
  assign converter_on = state_reg.ctrl.converter_on; // R1
  assign burst_sequence_on = state_reg.ctrl.burst_sequence_on; // R2
  assign conv_start = state_reg.start;
  assign sfr_rdata = state_reg.rdata;
  assign done_flag_out = state_reg.ctrl.conversion_done_flag;
  assign window_flag_out = state_reg.ctrl.window_match_flag; // R12

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  AST_OFF_NO_START: assert property ( // R1
    !state_next.ctrl.converter_on |=> !conv_start)
    else $error("start issued while converter off");

  AST_BURST_FOLLOWS: assert property ( // R2
    ctrl_wr |=> burst_sequence_on == $past(sfr_req.wdata[ACS_POS_BURST]))
    else $error("burst output does not follow write");

  AST_ON_FOLLOWS: assert property ( // R1
    ctrl_wr |=> converter_on == $past(sfr_req.wdata[ACS_POS_ON]))
    else $error("enable output does not follow write");

  AST_DONE_SINGLE: assert property ( // R3
    core_evt.conv_end && !burst_sequence_on |=> done_flag_out)
    else $error("done flag not set after single conversion");

  AST_DONE_BURST: assert property ( // R3
    core_evt.burst_end && burst_sequence_on |=> done_flag_out)
    else $error("done flag not set after burst");

  AST_SW_START: assert property ( // R4
    sw_go && wr_ctrl.converter_on &&
    !state_reg.ctrl.conversion_trigger_busy |=> conv_start ##1 !conv_start)
    else $error("software start not issued as one pulse");

  AST_TMR0_START: assert property ( // R6
    !ctrl_wr && state_reg.ctrl.start_source_select == ACS_SRC_TMR0 &&
    converter_on && !state_reg.ctrl.conversion_trigger_busy &&
    trig.tmr0_ovf |=> conv_start)
    else $error("timer zero overflow did not start");

  // timer two, like timers zero and three, has its own check; it alone also has a cover point
  AST_TMR2_START: assert property ( // R7
    !ctrl_wr && state_reg.ctrl.start_source_select == ACS_SRC_TMR2 &&
    converter_on && !state_reg.ctrl.conversion_trigger_busy &&
    trig.tmr2_ovf |=> conv_start)
    else $error("timer two overflow did not start");

  AST_TMR3_START: assert property ( // R8
    !ctrl_wr && state_reg.ctrl.start_source_select == ACS_SRC_TMR3 &&
    converter_on && !state_reg.ctrl.conversion_trigger_busy &&
    trig.tmr3_ovf |=> conv_start)
    else $error("timer three overflow did not start");

  AST_PIN_LEVEL: assert property ( // R9
    state_reg.ctrl.start_source_select == ACS_SRC_PIN && !ctrl_wr &&
    trig.external_start_pin && $past(trig.external_start_pin) |=> !conv_start)
    else $error("steady pin level started a conversion");

  // prev level is zero after reset, but the enable is off then as well
  AST_PIN_EDGE: assert property ( // R9
    state_reg.ctrl.start_source_select == ACS_SRC_PIN && !ctrl_wr &&
    converter_on && !state_reg.ctrl.conversion_trigger_busy &&
    trig.external_start_pin && !$past(trig.external_start_pin)
    |=> conv_start)
    else $error("pin rising edge did not start");

  AST_WIN_SET: assert property ( // R11
    core_evt.result_valid && win_match |=> window_flag_out)
    else $error("window flag not set on match");

  AST_WIN_HOLD: assert property ( // R12
    window_flag_out && !ctrl_wr |=> window_flag_out)
    else $error("window flag cleared by hardware");

  AST_WIN_NO_FALSE: assert property ( // R11
    !window_flag_out && !ctrl_wr &&
    !(core_evt.result_valid && win_match) |=> !window_flag_out)
    else $error("window flag set without a match");

  // a done flag lost to a later cycle would hide a finished conversion
  AST_DONE_HOLD: assert property ( // R3
    done_flag_out && !ctrl_wr |=> done_flag_out)
    else $error("done flag cleared by hardware");

  AST_RESET_ZERO: assert property ( // R13
    disable iff (1'b0) !rstn |=> state_reg.ctrl == ACS_CTRL_RESET)
    else $error("control register not zero after reset");

  COV_SW_START: cover property (sw_go ##1 conv_start);
  COV_PIN_START: cover property (
    state_reg.ctrl.start_source_select == ACS_SRC_PIN ##1 conv_start);
  COV_BURST_DONE: cover property (burst_sequence_on && core_evt.burst_end);
  COV_WIN_SET: cover property (!window_flag_out ##1 window_flag_out);
  COV_TMR2_START: cover property (
    state_reg.ctrl.start_source_select == ACS_SRC_TMR2 ##1 conv_start);

endmodule

// [design/acs_pkg.sv]
// package: constants and carrier types for the converter start/select control
//
// Overview of operation
// (R1) Enable bit 7 low keeps the converter in low-power shutdown, high makes it active.
// (R2) Bit 6 high runs the converter in burst operation, low turns burst off.
// (R3) Hardware sets the done flag (bit 5) at a single conversion end (burst off) or burst end (burst on); only software clears it.
// (R4) With source code 0x0, software writing 1 to the busy bit starts one conversion.
// (R5) Software detects the end of a conversion from the done flag, not by polling busy.
// (R6) With source code 0x1, each overflow of timer zero starts a conversion.
// (R7) With source code 0x2, each overflow of timer two starts a conversion.
// (R8) With source code 0x3, each overflow of timer three starts a conversion.
// (R9) With source code 0x4, each rising edge of the external start pin starts a conversion.
// (R10) The source field is bits 2:0 and software uses only the five defined codes.
// (R11) Hardware sets the window flag (bit 3) when the result lies in the window of the two limits.
// (R12) The window flag stays set until software clears it; hardware never clears it.
// (R13) After reset every control bit is 0, the source field 0x0 included.
// (R14) The order of the upper and lower limits decides inside-window or outside-window matching.
// (R15) Start triggers from every source are ignored while the enable bit is 0.
package acs_pkg;

  // register address on the special-function bus
  localparam logic [7:0] ACS_CTRL_ADDR = 8'h00_E8;
  localparam logic [7:0] ACS_CTRL_RESET = 8'h00_00;

  // bit positions within the control register
  localparam int ACS_POS_ON = 7;
  localparam int ACS_POS_BURST = 6;
  localparam int ACS_POS_DONE = 5;
  localparam int ACS_POS_BUSY = 4;
  localparam int ACS_POS_WIN = 3;
  localparam int ACS_POS_SRC = 0;

  // start-of-conversion source codes
  localparam logic [2:0] ACS_SRC_SW = 3'h0;
  localparam logic [2:0] ACS_SRC_TMR0 = 3'h1;
  localparam logic [2:0] ACS_SRC_TMR2 = 3'h2;
  localparam logic [2:0] ACS_SRC_TMR3 = 3'h3;
  localparam logic [2:0] ACS_SRC_PIN = 3'h4;

  localparam int ACS_RES_W = 16;

  // control register layout, msb first
  typedef struct packed {
    logic converter_on;
    logic burst_sequence_on;
    logic conversion_done_flag;
    logic conversion_trigger_busy;
    logic window_match_flag;
    logic [2:0] start_source_select;
  } acs_ctrl_t;

  // special-function bus request
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } acs_sfr_req_t;

  // events reported by the converter core
  typedef struct packed {
    logic conv_end;
    logic burst_end;
    logic result_valid;
    logic [ACS_RES_W-1:0] conversion_result;
  } acs_core_evt_t;

  // comparison limits held outside this block
  typedef struct packed {
    logic [ACS_RES_W-1:0] upper_compare_limit;
    logic [ACS_RES_W-1:0] lower_compare_limit;
  } acs_limits_t;

  // start trigger inputs
  typedef struct packed {
    logic tmr0_ovf;
    logic tmr2_ovf;
    logic tmr3_ovf;
    logic external_start_pin;
  } acs_trig_t;

endpackage

// [design/acs_window.sv]
// module: window comparator for the conversion result
`timescale 1ns/1ps
module acs_window
  import acs_pkg::*;
(
  // compared values
  input wire logic [acs_pkg::ACS_RES_W-1:0] result,
  input wire acs_pkg::acs_limits_t limits,
  // comparison outcome
  output logic match
);

  ////////////////////////////////////////////////////////////////////////////
  // lower above upper selects inside matching, otherwise outside matching
  always_comb
  begin
    if (limits.lower_compare_limit > limits.upper_compare_limit)
    begin
      match = (result > limits.upper_compare_limit) &&
              (result < limits.lower_compare_limit); // R14
    end
    else
    begin
      match = (result > limits.upper_compare_limit) ||
              (result < limits.lower_compare_limit); // R14
    end
  end

endmodule

// [verif/acs_core_model.sv]
// converter core stand-in: answers each start with timed end events
`timescale 1ns/1ps
module acs_core_model
  import acs_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // control from the block, result value from the bench
  input wire logic conv_start,
  input wire logic burst_sequence_on,
  input wire logic [acs_pkg::ACS_RES_W-1:0] res_val,
  // events back to the block
  output acs_pkg::acs_core_evt_t core_evt
);
  logic [3:0] cnt;
  logic fin;
  // one conversion takes four cycles; a burst is two back to back
  assign fin = (cnt == 4'h4 && !burst_sequence_on) || cnt == 4'h8;
  // cycle counter of the conversion in flight
  always_ff @(posedge sys_clk)
  begin
    if (!rstn || fin)
      cnt <= 4'h0;
    else if (conv_start || cnt != 4'h0)
      cnt <= cnt + 4'h1;
  end
  // result toggles outside valid cycles so a stale value never matches
  always_comb
  begin
    core_evt.conv_end = cnt == 4'h4 || cnt == 4'h8;
    core_evt.burst_end = burst_sequence_on && cnt == 4'h8;
    core_evt.result_valid = core_evt.conv_end;
    core_evt.conversion_result = core_evt.conv_end ? res_val : ~res_val;
  end
endmodule

// [verif/acs_ctrl_test.sv]
// self-checking bench for the converter control register
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module acs_ctrl_test;
  import acs_pkg::*;
  logic sys_clk = 0;
  logic rstn = 0;
  acs_sfr_req_t sfr_req = '0;
  acs_trig_t trig = '0;
  acs_limits_t limits = '0;
  logic [ACS_RES_W-1:0] res_val = '0;
  acs_core_evt_t core_evt;
  logic [7:0] sfr_rdata;
  logic converter_on, burst_sequence_on, conv_start;
  logic done_flag_out, window_flag_out;
  int errors = 0;
  int checks_done = 0;
  int starts = 0;
  int n;

  always #10 sys_clk = ~sys_clk;
  // count start pulses as the core would see them
  always @(posedge sys_clk)
    if (conv_start === 1'b1)
      starts++;

  acs_ctrl dut (.sys_clk(sys_clk), .rstn(rstn), .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata), .core_evt(core_evt), .limits(limits),
    .converter_on(converter_on), .burst_sequence_on(burst_sequence_on),
    .conv_start(conv_start), .trig(trig), .done_flag_out(done_flag_out),
    .window_flag_out(window_flag_out));
  acs_core_model core (.sys_clk(sys_clk), .rstn(rstn),
    .conv_start(conv_start), .burst_sequence_on(burst_sequence_on),
    .res_val(res_val), .core_evt(core_evt));

  ////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    if (errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // bus cycles start and end at a falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge sys_clk) sfr_req.wr = 1'b0;
    // idle cycle so the next request is not driven in this time step
    @(negedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    sfr_req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00_00};
    @(negedge sys_clk) sfr_req.rd = 1'b0;
    @(negedge sys_clk) `CHK(sfr_rdata, e)
  endtask
  task automatic pulse(input int b);
    trig[b] = 1'b1;
    @(negedge sys_clk) trig[b] = 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask
  // bounded poll of the done flag, never of busy
  task automatic wait_done;
    for (n = 0; n < 40 && done_flag_out !== 1'b1; n++)
      @(negedge sys_clk);
    if (n == 40)
    begin
      errors++;
      give_verdict();
    end
  endtask
  task automatic sw_conv(input logic [15:0] r, input logic [7:0] c);
    res_val = r;
    wr(ACS_CTRL_ADDR, c);
    wait_done();
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20) @(negedge sys_clk);
    rstn = 1;
    rd(ACS_CTRL_ADDR, 8'h00_00);
    `CHK(converter_on, 1'b0)
    // triggers and software starts while off are dropped
    wr(ACS_CTRL_ADDR, 8'h00_01);
    pulse(3);
    wr(ACS_CTRL_ADDR, 8'h00_10);
    repeat (8) @(negedge sys_clk);
    `CHK(starts, 0)
    wr(ACS_CTRL_ADDR, 8'h00_80);
    `CHK(converter_on, 1'b1)
    wr(8'h00_E9, 8'h00_C3);
    rd(8'h00_E9, 8'h00_00);
    rd(ACS_CTRL_ADDR, 8'h00_80);
    // above-limit window: boundary value does not match
    limits = '{upper_compare_limit: 16'h0080, lower_compare_limit: 16'h0};
    sw_conv(16'h0080, 8'h00_90);
    `CHK(starts, 1)
    rd(ACS_CTRL_ADDR, 8'h00_A0);
    sw_conv(16'h0081, 8'h00_90);
    `CHK(window_flag_out, 1'b1)
    // the start write keeps the window flag by writing its bit as 1
    sw_conv(16'h0010, 8'h00_98);
    `CHK(window_flag_out, 1'b1)
    wr(ACS_CTRL_ADDR, 8'h00_80);
    rd(ACS_CTRL_ADDR, 8'h00_80);
    // inside window when lower limit is above upper
    limits = '{upper_compare_limit: 16'h0040, lower_compare_limit: 16'h0080};
    sw_conv(16'h0041, 8'h00_90);
    `CHK(window_flag_out, 1'b1)
    // above both limits matches only in outside mode
    sw_conv(16'h0090, 8'h00_90);
    `CHK(window_flag_out, 1'b0)
    // each hardware source, with a foreign trigger first
    for (int s = 1; s <= 4; s++)
    begin
      wr(ACS_CTRL_ADDR, 8'h00_80 | 8'(s));
      pulse(4 - (s % 4 + 1));
      repeat (6) @(negedge sys_clk);
      `CHK(starts, s + 4)
      pulse(4 - s);
      wait_done();
      `CHK(starts, s + 5)
    end
    // burst: done only after the whole burst
    wr(ACS_CTRL_ADDR, 8'h00_C1);
    `CHK(burst_sequence_on, 1'b1)
    pulse(3);
    repeat (5) @(negedge sys_clk);
    `CHK(done_flag_out, 1'b0)
    wait_done();
    `CHK(starts, 10)
    give_verdict();
  end
endmodule
